// [spb_pkg.sv]
// Constants, register map and state record of the serial port block.
// Assumes one 10 MHz clock that stands for the oscillator.
package spb_pkg;

	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_BUF    = 8'h04;
	localparam logic [7:0] OFF_PWR    = 8'h08;
	localparam logic [7:0] OFF_RELOAD = 8'h0c;
	localparam logic [7:0] OFF_TMODE  = 8'h10;
	localparam logic [7:0] OFF_STAT   = 8'h14;

	// Register fields: control, power and timer mode
	localparam int CTL_MODE_HI = 7;
	localparam int CTL_MODE_LO = 6;
	localparam int CTL_FILTER  = 5;
	localparam int CTL_RX_EN   = 4;
	localparam int CTL_RX9     = 2;
	localparam int CTL_TX_DONE = 1;
	localparam int CTL_RX_DONE = 0;
	localparam int PWR_DOUBLE  = 7;
	localparam int TMODE_T1_HI = 5;
	localparam int TMODE_T1_LO = 4;

	localparam logic [1:0] MODE_SHIFT = 2'b00;
	localparam logic [1:0] MODE_FIXED = 2'b10;
	localparam logic [1:0] T1_AUTO    = 2'b10;

	// Machine cycle phases, S1P1 = 0 .. S6P2 = 11
	localparam logic [3:0] PH_S1P1 = 4'h0;
	localparam logic [3:0] PH_S3P1 = 4'h4;
	localparam logic [3:0] PH_S5P2 = 4'h9;
	localparam logic [3:0] PH_S6P2 = 4'hb;

	localparam logic [3:0] DIV16_LAST = 4'hf;
	localparam logic [3:0] SMP_FIRST  = 4'h6;
	localparam logic [3:0] SMP_LAST   = 4'h8;
	localparam logic [1:0] PRE_LAST   = 2'b11;
	localparam logic [7:0] T1_TOP     = 8'hff;
	localparam logic [7:0] RX0_INIT   = 8'hfe;
	localparam logic [8:0] RX1_INIT   = 9'h1ff;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} spb_apb_req_s;

	typedef struct packed {
		logic [3:0] ph;
		logic [7:0] ctrl;
		logic [7:0] rbuf;
		logic       dbl;
		logic [7:0] reload;
		logic [7:0] tmode;
		logic [7:0] t1;
		logic       t1half;
		logic [1:0] pre;
		logic       sync1;
		logic       sync2;
		logic [8:0] txsh;
		logic       m0_wpend;
		logic       m0_req;
		logic       m1_req;
		logic       m1_start;
		logic       tx_active;
		logic       tx_data;
		logic       tx_end;
		logic [3:0] txdiv;
		logic       rx0_arm;
		logic       rx0_go;
		logic       rx0_act;
		logic       rx0_end;
		logic       smp;
		logic [7:0] rxsh8;
		logic       rx1_act;
		logic [3:0] rxdiv;
		logic [2:0] smpv;
		logic [8:0] rxsh9;
		logic       rxprev;
		logic       p1;
		logic       p0o;
		logic       p0oe;
	} spb_state_s;

	localparam spb_state_s ST_RESET = '{p1: 1'b1, p0o: 1'b1, rxprev: 1'b1, default: '0};

endpackage : spb_pkg

// [spb_serial_port.sv]
// Serial port: rate generation, shift-register mode and 10-bit asynchronous mode.
// Assumes an APB master on clk; alt_pin_zero input arrives from outside and is synchronised.
`timescale 1ns/1ps
module spb_serial_port
	import spb_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire spb_apb_req_s apb_req,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	input  wire logic         alt_pin_zero_in,
	output logic              alt_pin_zero_out,
	output logic              alt_pin_zero_oe,
	output logic              alt_pin_one,
	output logic              serial_irq
);

	function automatic logic [7:0] rev8(input logic [7:0] v);
		logic [7:0] r;
		r = '0;
		for (int i = 0; i < 8; i++)
			r[i] = v[7 - i];
		return r;
	endfunction : rev8

	function automatic logic maj3(input logic [2:0] v);
		return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
	endfunction : maj3

	spb_state_s s_ff;
	spb_state_s nxt_s;

	logic       access;
	logic       wr;
	logic       mapped;
	logic       mc_end;
	logic       t1ovf;
	logic       tick16;
	logic       txroll;
	logic       bitval;
	logic       ti_set;
	logic       ri_set;
	logic       shclk;
	logic [1:0] mode;

	assign access = apb_req.psel & apb_req.penable;
	assign wr     = access & apb_req.pwrite;
	assign mode   = s_ff.ctrl[CTL_MODE_HI:CTL_MODE_LO];

	always_comb
	begin
		mapped = 1'b1;
		prdata = '0;
		// Reads have no side effects; flags clear only by writing the control word
		if (apb_req.paddr == OFF_CTRL)
			prdata = {24'h0, s_ff.ctrl};
		else if (apb_req.paddr == OFF_BUF)
			prdata = {24'h0, s_ff.rbuf};
		else if (apb_req.paddr == OFF_PWR)
			prdata = {24'h0, s_ff.dbl, 7'h0};
		else if (apb_req.paddr == OFF_RELOAD)
			prdata = {24'h0, s_ff.reload};
		else if (apb_req.paddr == OFF_TMODE)
			prdata = {24'h0, s_ff.tmode};
		else if (apb_req.paddr == OFF_STAT)
			prdata = {30'h0, s_ff.rx0_act | s_ff.rx1_act, s_ff.tx_active};
		else
			mapped = 1'b0;
	end

	assign pready  = 1'b1;
	assign pslverr = access & ~mapped;

	always_comb
	begin
		nxt_s  = s_ff;
		ti_set = 1'b0;
		ri_set = 1'b0;
		t1ovf  = 1'b0;
		tick16 = 1'b0;
		txroll = 1'b0;
		bitval = 1'b0;
		shclk  = 1'b1;

		nxt_s.sync1 = alt_pin_zero_in;
		nxt_s.sync2 = s_ff.sync1;

		// Twelve phases per machine cycle
		nxt_s.ph = (s_ff.ph == PH_S6P2) ? PH_S1P1 : s_ff.ph + 4'h1;
		mc_end   = (s_ff.ph == PH_S6P2);

		// Timer 1, 8-bit auto-reload at machine cycle rate
		if (mc_end && s_ff.tmode[TMODE_T1_HI:TMODE_T1_LO] == T1_AUTO)
		begin
			if (s_ff.t1 == T1_TOP)
			begin
				nxt_s.t1 = s_ff.reload;
				t1ovf    = 1'b1;
			end
			else
				nxt_s.t1 = s_ff.t1 + 8'h1;
		end

		// Sixteen-times rate; the bit divider then gives one more /16
		if (mode == MODE_FIXED)
		begin
			nxt_s.pre = s_ff.pre + 2'h1;
			tick16    = s_ff.dbl ? s_ff.pre[0] : (s_ff.pre == PRE_LAST);
		end
		else
		begin
			if (t1ovf)
				nxt_s.t1half = ~s_ff.t1half;
			// Undoubled rate halves the overflows
			tick16 = t1ovf & (s_ff.dbl | s_ff.t1half);
		end

		if (mode == MODE_SHIFT)
		begin
			// Transmit, one bit per machine cycle
			if (mc_end)
			begin
				nxt_s.m0_wpend = 1'b0;
				if (s_ff.m0_wpend)
					nxt_s.m0_req = 1'b1;
				else if (s_ff.m0_req)
				begin
					nxt_s.m0_req    = 1'b0;
					nxt_s.tx_active = 1'b1;
				end
				else if (s_ff.tx_active && !s_ff.tx_end)
				begin
					nxt_s.txsh = s_ff.txsh >> 1;
					if (s_ff.txsh[8:2] == 7'h0)
						nxt_s.tx_end = 1'b1;
				end
			end
			if (s_ff.ph == PH_S1P1 && s_ff.tx_end)
			begin
				nxt_s.tx_active = 1'b0;
				nxt_s.tx_end    = 1'b0;
				ti_set          = 1'b1;
			end

			// Receive, armed while enabled and the done flag is clear
			if (s_ff.ctrl[CTL_RX_EN] && !s_ff.ctrl[CTL_RX_DONE] && !s_ff.rx0_arm && !s_ff.rx0_go
				&& !s_ff.rx0_act)
				nxt_s.rx0_arm = 1'b1;
			if (s_ff.ph == PH_S1P1 && s_ff.rx0_arm)
			begin
				nxt_s.rx0_arm = 1'b0;
				nxt_s.rx0_go  = 1'b1;
			end
			if (s_ff.ph == PH_S5P2)
				nxt_s.smp = s_ff.sync2;
			if (mc_end && s_ff.rx0_go)
			begin
				nxt_s.rx0_go  = 1'b0;
				nxt_s.rxsh8   = RX0_INIT;
				nxt_s.rx0_act = 1'b1;
			end
			else if (mc_end && s_ff.rx0_act && !s_ff.rx0_end)
			begin
				nxt_s.rxsh8 = {s_ff.rxsh8[6:0], s_ff.smp};
				// Marker at the top: this shift completes the byte
				if (!s_ff.rxsh8[7])
				begin
					nxt_s.rbuf    = rev8({s_ff.rxsh8[6:0], s_ff.smp});
					nxt_s.rx0_end = 1'b1;
				end
			end
			if (s_ff.ph == PH_S1P1 && s_ff.rx0_end)
			begin
				nxt_s.rx0_act = 1'b0;
				nxt_s.rx0_end = 1'b0;
				ri_set        = 1'b1;
			end
		end
		else
		begin
			// Transmit, bit times locked to the transmit divider
			if (tick16)
				nxt_s.txdiv = s_ff.txdiv + 4'h1;
			txroll = tick16 & (s_ff.txdiv == DIV16_LAST);
			if (txroll)
			begin
				if (s_ff.m1_req && !s_ff.tx_active)
				begin
					nxt_s.m1_req   = 1'b0;
					nxt_s.m1_start = 1'b1;
				end
				else if (s_ff.tx_active && !s_ff.tx_data)
					nxt_s.tx_data = 1'b1;
				else if (s_ff.tx_data)
				begin
					nxt_s.txsh = s_ff.txsh >> 1;
					if (s_ff.txsh[8:2] == 7'h0)
					begin
						nxt_s.tx_active = 1'b0;
						nxt_s.tx_data   = 1'b0;
						ti_set          = 1'b1;
					end
				end
			end
			if (s_ff.m1_start && s_ff.ph == PH_S1P1)
			begin
				nxt_s.m1_start  = 1'b0;
				nxt_s.tx_active = 1'b1;
			end

			// Receive, hunting and bit detection at sixteen times the rate
			if (!s_ff.ctrl[CTL_RX_EN])
				nxt_s.rx1_act = 1'b0;
			else if (tick16)
			begin
				nxt_s.rxprev = s_ff.sync2;
				if (!s_ff.rx1_act)
				begin
					if (s_ff.rxprev && !s_ff.sync2)
					begin
						nxt_s.rx1_act = 1'b1;
						nxt_s.rxdiv   = 4'h0;
						nxt_s.rxsh9   = RX1_INIT;
					end
				end
				else
				begin
					nxt_s.rxdiv = s_ff.rxdiv + 4'h1;
					if (s_ff.rxdiv >= SMP_FIRST && s_ff.rxdiv <= SMP_LAST)
						nxt_s.smpv = {s_ff.smpv[1:0], s_ff.sync2};
					if (s_ff.rxdiv == DIV16_LAST)
					begin
						bitval = maj3(s_ff.smpv);
						if (s_ff.rxsh9 == RX1_INIT)
						begin
							// False start is dropped to reject glitches
							if (bitval)
								nxt_s.rx1_act = 1'b0;
							else
								nxt_s.rxsh9 = {s_ff.rxsh9[7:0], bitval};
						end
						else if (!s_ff.rxsh9[8])
						begin
							if (!s_ff.ctrl[CTL_RX_DONE] && (!s_ff.ctrl[CTL_FILTER] || bitval))
							begin
								nxt_s.rbuf = rev8(s_ff.rxsh9[7:0]);
								ri_set     = 1'b1;
							end
							nxt_s.rx1_act = 1'b0;
						end
						else
							nxt_s.rxsh9 = {s_ff.rxsh9[7:0], bitval};
					end
				end
			end
		end

		// Software writes come after the engines so a new load is not shifted away
		if (wr)
		begin
			if (apb_req.paddr == OFF_CTRL)
				nxt_s.ctrl = apb_req.pwdata[7:0];
			else if (apb_req.paddr == OFF_BUF)
			begin
				nxt_s.txsh = {1'b1, apb_req.pwdata[7:0]};
				if (mode == MODE_SHIFT)
					nxt_s.m0_wpend = 1'b1;
				else
					nxt_s.m1_req = 1'b1;
			end
			else if (apb_req.paddr == OFF_PWR)
				nxt_s.dbl = apb_req.pwdata[PWR_DOUBLE];
			else if (apb_req.paddr == OFF_RELOAD)
				nxt_s.reload = apb_req.pwdata[7:0];
			else if (apb_req.paddr == OFF_TMODE)
				nxt_s.tmode = apb_req.pwdata[7:0];
		end

		// Hardware sets win over a clear in the same cycle
		if (ti_set)
			nxt_s.ctrl[CTL_TX_DONE] = 1'b1;
		if (ri_set)
			nxt_s.ctrl[CTL_RX_DONE] = 1'b1;
		if (ri_set && mode != MODE_SHIFT)
			nxt_s.ctrl[CTL_RX9] = bitval;

		// Pins, registered
		shclk = !(nxt_s.ph >= PH_S3P1 && nxt_s.ph <= PH_S5P2);
		if (mode == MODE_SHIFT)
		begin
			nxt_s.p1   = (nxt_s.tx_active || nxt_s.rx0_act) ? shclk : 1'b1;
			nxt_s.p0oe = nxt_s.tx_active;
			nxt_s.p0o  = nxt_s.tx_active ? nxt_s.txsh[0] : 1'b1;
		end
		else
		begin
			nxt_s.p0oe = 1'b0;
			nxt_s.p0o  = 1'b1;
			// Idle and stop level is high
			nxt_s.p1 = !nxt_s.tx_active ? 1'b1 : (!nxt_s.tx_data ? 1'b0 : nxt_s.txsh[0]);
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			s_ff <= ST_RESET;
		else
			s_ff <= nxt_s;
	end

	assign alt_pin_zero_out = s_ff.p0o;
	assign alt_pin_zero_oe  = s_ff.p0oe;
	assign alt_pin_one      = s_ff.p1;
	assign serial_irq       = s_ff.ctrl[CTL_RX_DONE] | s_ff.ctrl[CTL_TX_DONE];

endmodule : spb_serial_port

// [spb_serial_port_properties.sv]
// Checker on the serial port pins and bus answers.
// Assumes it is bound to spb_serial_port; one clock domain.
`timescale 1ns/1ps
module spb_chk
	import spb_pkg::*;
(
	input wire logic         clk,
	input wire logic         reset,
	input wire spb_apb_req_s apb_req,
	input wire logic [31:0]  prdata,
	input wire logic         pready,
	input wire logic         pslverr,
	input wire logic         alt_pin_zero_out,
	input wire logic         alt_pin_zero_oe,
	input wire logic         alt_pin_one,
	input wire logic         serial_irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	wire logic acc = apb_req.psel & apb_req.penable;
	wire logic hit = apb_req.paddr inside {OFF_CTRL, OFF_BUF, OFF_PWR, OFF_RELOAD, OFF_TMODE, OFF_STAT};
	property p_lo; $fell(alt_pin_one) |-> !alt_pin_one [*6]; endproperty
	a_lo: assert property (p_lo) else $error("shift clock low too short");
	property p_hi; $rose(alt_pin_one) |-> alt_pin_one [*6]; endproperty
	a_hi: assert property (p_hi) else $error("shift clock high too short");
	property p_dat; $changed(alt_pin_zero_out) && alt_pin_zero_oe |=> $stable(alt_pin_zero_out) [*8]; endproperty
	a_dat: assert property (p_dat) else $error("data bit shorter than a cycle");
	property p_edge; $changed(alt_pin_zero_out) && alt_pin_zero_oe |-> alt_pin_one && $past(alt_pin_one); endproperty
	a_edge: assert property (p_edge) else $error("data moved while clock low");
	property p_end; $fell(alt_pin_zero_oe) |-> ##[0:1] serial_irq; endproperty
	a_end: assert property (p_end) else $error("send ended without done");
	property p_irq; acc && !apb_req.pwrite && apb_req.paddr == OFF_CTRL
		|-> serial_irq == (prdata[CTL_TX_DONE] | prdata[CTL_RX_DONE]); endproperty
	a_irq: assert property (p_irq) else $error("irq not or of flags");
	property p_err; acc && !hit |-> pslverr && prdata == 32'h0; endproperty
	a_err: assert property (p_err) else $error("unmapped access not refused");
	property p_ok; acc && hit |-> pready && !pslverr && prdata[31:8] == 24'h0; endproperty
	a_ok: assert property (p_ok) else $error("mapped access answered wrongly");
	c_tx: cover property ($rose(alt_pin_zero_oe));
	c_err: cover property (acc && pslverr);
	c_irq: cover property ($rose(serial_irq));
endmodule : spb_chk

bind spb_serial_port spb_chk u_chk (.clk(clk), .reset(reset), .apb_req(apb_req), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .alt_pin_zero_out(alt_pin_zero_out),
	.alt_pin_zero_oe(alt_pin_zero_oe), .alt_pin_one(alt_pin_one), .serial_irq(serial_irq));

// [spb_peer.sv]
// Far side: shift register for mode 0, serial peer for modes 1 to 3.
// Assumes the bench puts its line on the data pin while the block does not drive it.
`timescale 1ns/1ps
module spb_peer
(
	input  wire logic clk,
	input  wire logic shclk,
	output logic      line
);
	logic [7:0] sr = 8'hff;
	logic       la = 1'b1;
	logic       sc = 1'b1;
	// Pull-up on the pin, so spent bits read 1
	assign line = la & sr[0];
	always @(posedge clk)
	begin
		sc <= shclk;
		if (shclk && !sc)
			sr <= {1'b1, sr[7:1]};
	end
	task automatic load(input logic [7:0] d);
		@(posedge clk) sr <= d;
	endtask : load
	task automatic send(input logic [7:0] d, input logic s, input int w);
		logic [9:0] f;
		f = {s, d, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			@(posedge clk) la <= f[i];
			repeat (w - 1) @(posedge clk);
		end
		@(posedge clk) la <= 1'b1;
	endtask : send
	task automatic glitch(input int n);
		@(posedge clk) la <= 1'b0;
		repeat (n) @(posedge clk);
		la <= 1'b1;
		repeat (300) @(posedge clk);
	endtask : glitch
endmodule : spb_peer

// [spb_serial_port_tb_top.sv]
// Bench for the serial port: bus tasks and one task per scenario.
// Assumes spb_peer on the data pin and the checker bound to the block.
`timescale 1ns/1ps
module spb_serial_port_tb_top
	import spb_pkg::*;
;
	logic         clk = 1'b0;
	logic         reset = 1'b1;
	spb_apb_req_s req = '0;
	logic [31:0]  prdata, q;
	logic         pready, pslverr, e, zo, zoe, p1, irq, pl;
	int           n_fail = 0;
	int           n_tests = 0;
	wire logic    zi = zoe ? zo : pl;
	spb_serial_port u_dut (.clk(clk), .reset(reset), .apb_req(req), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .alt_pin_zero_in(zi), .alt_pin_zero_out(zo), .alt_pin_zero_oe(zoe),
		.alt_pin_one(p1), .serial_irq(irq));
	spb_peer u_peer (.clk(clk), .shclk(p1), .line(pl));
	initial forever #50 clk = ~clk;
	task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
		n_tests++;
		if (g !== x)
		begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", s, x, g);
		end
	endtask : chk
	task automatic tally_and_finish();
		if (n_fail == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish
	// Request stands until pready is seen high at a rising edge; answer taken there
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk) req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk) req.penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		q = prdata;
		e = pslverr;
		req <= '0;
	endtask : apb
	task automatic wirq(input int n);
		for (int k = 0; k < n; k++)
		begin
			@(negedge clk);
			if (irq === 1'b1)
				return;
		end
		chk("irq", 1, irq);
	endtask : wirq
	task automatic wlow(input int n, input logic v = 1'b0);
		int t;
		for (t = 0; t < n; t++)
		begin
			@(negedge clk);
			if (p1 === v)
				break;
		end
		chk("line level in time", 1, t < n);
	endtask : wlow
	task automatic t_regs();
		apb(0, OFF_PWR, 0);
		chk("pwr reset", 0, q);
		apb(0, 8'h18, 0);
		chk("unmapped err", 1, e);
		chk("unmapped data", 0, q);
	endtask : t_regs
	task automatic t_m0tx();
		logic [7:0] d;
		d = 8'ha5;
		apb(1, OFF_CTRL, 0);
		apb(1, OFF_BUF, d);
		for (int t = 0; zoe !== 1'b1 && t < 30; t++)
			@(negedge clk);
		chk("m0 send", 1, zoe);
		for (int i = 0; i < 8; i++)
		begin
			chk("m0 bit", d[i], zo);
			repeat (12) @(negedge clk);
		end
		wirq(24);
		@(negedge clk);
		chk("m0 oe", 0, zoe);
	endtask : t_m0tx
	task automatic t_m0rx();
		u_peer.load(8'h3c);
		apb(1, OFF_CTRL, 8'h10);
		wirq(132);
		apb(0, OFF_BUF, 0);
		chk("m0 rx", 8'h3c, q);
		apb(0, OFF_CTRL, 0);
		chk("m0 ctrl", 8'h11, q);
	endtask : t_m0rx
	task automatic setup(input logic [7:0] c, input logic dbl, input logic [7:0] r);
		apb(1, OFF_CTRL, c);
		apb(1, OFF_PWR, {dbl, 7'h0});
		apb(1, OFF_RELOAD, r);
	endtask : setup
	// Start bit is cut short by the S1P1 wait; the low second data bit spans two rollovers
	task automatic rate(input logic [7:0] c, input logic dbl, input logic [7:0] r, input int w);
		int t;
		setup(c, dbl, r);
		apb(1, OFF_BUF, 8'hfd);
		wlow(w + 24);
		wlow(w + 2, 1'b1);
		wlow(w + 2);
		for (t = 1; t < 500; t++)
		begin
			@(negedge clk);
			if (p1 !== 1'b0)
				break;
		end
		chk("bit time", w, t);
		wirq(12 * w);
	endtask : rate
	task automatic m1tx(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		setup(8'h40, 1'b1, 8'hff);
		apb(1, OFF_BUF, d);
		wlow(216);
		repeat (96) @(negedge clk);
		for (int i = 0; i < 10; i++)
		begin
			chk("m1 bit", f[i], p1);
			repeat (192) @(negedge clk);
		end
		chk("m1 done", 1, irq);
	endtask : m1tx
	task automatic m1rx(input logic [7:0] d, input logic s, input logic [7:0] xb, input logic [7:0] xc);
		u_peer.send(d, s, 192);
		// Stop bit is judged up to fourteen clocks after the line frees
		repeat (24) @(posedge clk);
		apb(0, OFF_BUF, 0);
		chk("m1 rx", xb, q);
		apb(0, OFF_CTRL, 0);
		chk("m1 ctrl", xc, q);
	endtask : m1rx
	initial
	begin
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		t_regs();
		t_m0tx();
		t_m0rx();
		apb(1, OFF_RELOAD, 8'hff);
		apb(1, OFF_TMODE, 8'h20);
		// First overflow comes only after the counter climbs from zero
		repeat (3100) @(posedge clk);
		rate(8'h40, 1'b1, 8'hff, 192);
		rate(8'h40, 1'b0, 8'hff, 384);
		rate(8'h40, 1'b1, 8'hfe, 384);
		rate(8'h80, 1'b0, 8'hff, 64);
		rate(8'h80, 1'b1, 8'hff, 32);
		rate(8'hc0, 1'b1, 8'hff, 192);
		m1tx(8'h4b);
		apb(1, OFF_CTRL, 8'h50);
		m1rx(8'h96, 1'b1, 8'h96, 8'h55);
		m1rx(8'h11, 1'b1, 8'h96, 8'h55);
		apb(1, OFF_CTRL, 8'h70);
		m1rx(8'h22, 1'b0, 8'h96, 8'h70);
		u_peer.glitch(40);
		m1rx(8'h5a, 1'b1, 8'h5a, 8'h75);
		apb(1, OFF_CTRL, 8'h50);
		m1rx(8'h3c, 1'b0, 8'h3c, 8'h51);
		tally_and_finish();
	end
	initial
	begin
		repeat (60000) @(posedge clk);
		n_fail++;
		tally_and_finish();
	end
endmodule : spb_serial_port_tb_top
